// >>> hw/scrt_params.svh
// Register offsets, field positions, reset values and divider counts
`ifndef SCRT_PARAMS_SVH
`define SCRT_PARAMS_SVH

// Register offsets
`define SCRT_ADDR_CTRL    8'h91
`define SCRT_ADDR_RL_LO   8'h92
`define SCRT_ADDR_RL_HI   8'h93
`define SCRT_ADDR_CNT_LO  8'h94
`define SCRT_ADDR_CNT_HI  8'h95
`define SCRT_ADDR_CKCTL   8'h8e
`define SCRT_ADDR_STS     8'h96
`define SCRT_ADDR_MSK     8'h97

// Control register fields
`define SCRT_BIT_HI_FLAG  7
`define SCRT_BIT_LO_FLAG  6
`define SCRT_BIT_LO_IEN   5
`define SCRT_BIT_CAP_EN   4
`define SCRT_BIT_SPLIT    3
`define SCRT_BIT_RUN      2
`define SCRT_BIT_UNUSED   1
`define SCRT_BIT_XCLK     0
`define SCRT_CTRL_WMASK   8'hfd

// Clock control fields
`define SCRT_BIT_LO_CSEL  0
`define SCRT_BIT_HI_CSEL  1
`define SCRT_CKCTL_WMASK  8'h03

// Interrupt status fields
`define SCRT_EVT_HI       0
`define SCRT_EVT_LO       1
`define SCRT_EVT_CAP      2
`define SCRT_EVT_WMASK    8'h07

// Reset values
`define SCRT_RST_BYTE     8'h00

// Divider counts
`define SCRT_SYS_DIV      4'd12
`define SCRT_EXT_DIV      4'd8

`endif

// >>> hw/scrt_pkg.sv
// Types shared by the timer files
package scrt_pkg;

  typedef logic [7:0] scrt_byte_t;

  // Operating mode, coded as {capture enable, split enable}
  typedef enum logic [1:0] {
    SCRT_AUTO16 = 2'b00,
    SCRT_SPLIT8 = 2'b01,
    SCRT_CAP16  = 2'b10,
    SCRT_CAP8   = 2'b11
  } scrt_mode_t;

endpackage : scrt_pkg

// >>> hw/scrt_tick_gen.sv
// Count ticks: system clock by twelve and synchronised oscillator by eight
`timescale 1ns/1ps
`default_nettype none
`include "scrt_params.svh"

module scrt_tick_gen (
  input  wire logic clk_sys_in,
  input  wire logic rstn_in,
  input  wire logic ce_in,
  input  wire logic ext_osc_in,
  output logic      div12_tick_out,
  output logic      ext8_tick_out
);
  import scrt_pkg::*;

  logic       sync1_q;
  logic       sync2_q;
  logic       sync3_q;
  logic [3:0] sys_cnt_q;
  logic [3:0] ext_cnt_q;
  wire        ext_rise;
  wire        sys_last;
  wire        ext_last;

  // Rising edge seen only after the two-stage synchroniser
  assign ext_rise = sync2_q & ~sync3_q;
  assign sys_last = (sys_cnt_q == (`SCRT_SYS_DIV - 4'd1));
  assign ext_last = (ext_cnt_q == (`SCRT_EXT_DIV - 4'd1));
  assign div12_tick_out = ce_in & sys_last;
  assign ext8_tick_out  = ce_in & ext_rise & ext_last;

  // Synchroniser, then edge history for the detector
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else if (ce_in) begin
      sync1_q <= ext_osc_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Divider counters
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sys_cnt_q <= 4'h0;
      ext_cnt_q <= 4'h0;
    end else if (ce_in) begin
      sys_cnt_q <= sys_last ? 4'h0 : sys_cnt_q + 4'h1;
      if (ext_rise) begin
        ext_cnt_q <= ext_last ? 4'h0 : ext_cnt_q + 4'h1;
      end
    end
  end

endmodule : scrt_tick_gen
`default_nettype wire

// >>> hw/scrt_irq.sv
// Sticky event status, mask and level interrupt output
`timescale 1ns/1ps
`default_nettype none
`include "scrt_params.svh"

module scrt_irq (
  input  wire logic              clk_sys_in,
  input  wire logic              rstn_in,
  input  wire logic              ce_in,
  input  wire logic [2:0]        evt_in,
  input  wire logic              sts_wr_in,
  input  wire logic              msk_wr_in,
  input  wire scrt_pkg::scrt_byte_t wdata_in,
  output scrt_pkg::scrt_byte_t   sts_out,
  output scrt_pkg::scrt_byte_t   msk_out,
  output logic                   irq_out
);
  import scrt_pkg::*;

  logic [2:0] sts_q;
  logic [2:0] msk_q;
  logic       irq_q;
  wire  [2:0] sts_clr;
  wire  [2:0] sts_d;

  // Write one clears; a new event in the same cycle wins
  assign sts_clr = sts_wr_in ? wdata_in[2:0] : 3'b000;
  assign sts_d   = (sts_q & ~sts_clr) | evt_in;
  assign sts_out = {5'b00000, sts_q};
  assign msk_out = {5'b00000, msk_q};
  assign irq_out = irq_q;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sts_q <= 3'b000;
      msk_q <= 3'b000;
      irq_q <= 1'b0;
    end else if (ce_in) begin
      sts_q <= sts_d;
      if (msk_wr_in) begin
        msk_q <= wdata_in[2:0];
      end
      irq_q <= |(sts_q & msk_q);
    end
  end

endmodule : scrt_irq
`default_nettype wire

// >>> hw/scrt_timer.sv
// Timer with auto-reload, split byte and frame capture modes
`timescale 1ns/1ps
`default_nettype none
`include "scrt_params.svh"

// Behaviour
// - 16-bit mode counts up; on FFFF wrap loads reload and sets high flag.
// - 16-bit overflow interrupts; low byte wrap also when low enable set.
// - Split mode runs two 8-bit timers, each reloading from own byte.
// - Run bit gates the timer; in split mode only the high byte.
// - Split byte clock: system clock, else by twelve or external by eight.
// - External divided tick is synchronised to the system clock.
// - Split flags set per byte wrap; interrupts on high, or either if enabled.
// - Low flag sets on every low byte wrap in every mode.
// - Hardware never clears the flags; software writes zero.
// - An enabled set flag raises the timer interrupt request.
// - Capture 16-bit counts and wraps; frame start copies count to reload.
// - Capture split counts bytes, wrap to zero; frame copies both bytes.
// - One external select serves both bytes; each may pick system clock.
// - Control bit 1 reads zero and ignores writes.
// - Reload bytes hold reload or captured count, CPU read and write.
// - Count bytes are CPU read and write, one or two counts, reset zero.
module scrt_timer (
  input  wire logic                 clk_sys_in,
  input  wire logic                 rstn_in,
  input  wire logic                 ce_in,
  input  wire logic                 ext_osc_in,
  input  wire logic                 sof_pulse_in,
  input  wire logic [7:0]           addr_in,
  input  wire scrt_pkg::scrt_byte_t wdata_in,
  input  wire logic                 wr_in,
  input  wire logic                 rd_in,
  output scrt_pkg::scrt_byte_t      rdata_out,
  output logic                      irq_out
);
  import scrt_pkg::*;

  scrt_byte_t ctrl_q;
  scrt_byte_t ckctl_q;
  scrt_byte_t rl_lo_q;
  scrt_byte_t rl_hi_q;
  scrt_byte_t cnt_lo_q;
  scrt_byte_t cnt_hi_q;
  scrt_byte_t cnt_lo_d;
  scrt_byte_t cnt_hi_d;
  scrt_byte_t rdata_q;
  scrt_byte_t sts_w;
  scrt_byte_t msk_w;
  scrt_mode_t mode;
  logic       div12_tick;
  logic       ext8_tick;

  wire        wr_ctrl;
  wire        wr_ckctl;
  wire        wr_rl_lo;
  wire        wr_rl_hi;
  wire        wr_cnt_lo;
  wire        wr_cnt_hi;
  wire        wr_sts;
  wire        wr_msk;
  wire        run;
  wire        split;
  wire        cap_en;
  wire        xclk;
  wire        lo_ien;
  wire        alt_tick;
  wire        tick_lo;
  wire        tick_hi;
  wire        adv_lo;
  wire        adv_hi;
  wire        lo_wrap;
  wire        hi_wrap;
  wire        capture;
  wire [15:0] cnt16;
  wire [15:0] cnt16_inc;
  wire [2:0]  evt;
  wire [7:0]  rd_mux;
  wire [7:0]  ctrl_wr_val;
  wire [7:0]  ctrl_set;

  // Address decode for writes
  assign wr_ctrl   = wr_in & (addr_in == `SCRT_ADDR_CTRL);
  assign wr_ckctl  = wr_in & (addr_in == `SCRT_ADDR_CKCTL);
  assign wr_rl_lo  = wr_in & (addr_in == `SCRT_ADDR_RL_LO);
  assign wr_rl_hi  = wr_in & (addr_in == `SCRT_ADDR_RL_HI);
  assign wr_cnt_lo = wr_in & (addr_in == `SCRT_ADDR_CNT_LO);
  assign wr_cnt_hi = wr_in & (addr_in == `SCRT_ADDR_CNT_HI);
  assign wr_sts    = wr_in & (addr_in == `SCRT_ADDR_STS);
  assign wr_msk    = wr_in & (addr_in == `SCRT_ADDR_MSK);

  // Control fields and mode
  assign run    = ctrl_q[`SCRT_BIT_RUN];
  assign split  = ctrl_q[`SCRT_BIT_SPLIT];
  assign cap_en = ctrl_q[`SCRT_BIT_CAP_EN];
  assign xclk   = ctrl_q[`SCRT_BIT_XCLK];
  assign lo_ien = ctrl_q[`SCRT_BIT_LO_IEN];
  assign mode   = scrt_mode_t'({cap_en, split});

  // Tick sources
  scrt_tick_gen u_tick (
    .clk_sys_in     (clk_sys_in),
    .rstn_in        (rstn_in),
    .ce_in          (ce_in),
    .ext_osc_in     (ext_osc_in),
    .div12_tick_out (div12_tick),
    .ext8_tick_out  (ext8_tick)
  );

  // Per-byte clock choice, one external select for both
  assign alt_tick = xclk ? ext8_tick : div12_tick;
  assign tick_lo  = ckctl_q[`SCRT_BIT_LO_CSEL] ? ce_in : alt_tick;
  assign tick_hi  = ckctl_q[`SCRT_BIT_HI_CSEL] ? ce_in : alt_tick;

  // Advance enables; 16-bit modes carry from low byte
  assign adv_lo = split ? tick_lo : (tick_lo & run);
  assign adv_hi = split ? (tick_hi & run)
                        : (adv_lo & (cnt_lo_q == 8'hff));
  assign lo_wrap = adv_lo & (cnt_lo_q == 8'hff);
  assign hi_wrap = adv_hi & (cnt_hi_q == 8'hff);
  assign capture = cap_en & sof_pulse_in;

  assign cnt16     = {cnt_hi_q, cnt_lo_q};
  assign cnt16_inc = cnt16 + 16'h0001;

  // Next count per mode, before software writes
  always_comb begin
    cnt_lo_d = cnt_lo_q;
    cnt_hi_d = cnt_hi_q;
    unique case (mode)
      SCRT_AUTO16: begin
        if (hi_wrap) begin
          cnt_lo_d = rl_lo_q;
          cnt_hi_d = rl_hi_q;
        end else if (adv_lo) begin
          cnt_lo_d = cnt16_inc[7:0];
          cnt_hi_d = cnt16_inc[15:8];
        end
      end
      SCRT_CAP16: begin
        if (adv_lo) begin
          cnt_lo_d = cnt16_inc[7:0];
          cnt_hi_d = cnt16_inc[15:8];
        end
      end
      SCRT_SPLIT8: begin
        if (adv_lo) begin
          cnt_lo_d = lo_wrap ? rl_lo_q : cnt_lo_q + 8'h01;
        end
        if (adv_hi) begin
          cnt_hi_d = hi_wrap ? rl_hi_q : cnt_hi_q + 8'h01;
        end
      end
      SCRT_CAP8: begin
        if (adv_lo) begin
          cnt_lo_d = cnt_lo_q + 8'h01;
        end
        if (adv_hi) begin
          cnt_hi_d = cnt_hi_q + 8'h01;
        end
      end
    endcase
  end

  // Flag setting wins over a software clear in the same cycle
  assign ctrl_wr_val = wr_ctrl ? (wdata_in & `SCRT_CTRL_WMASK)
                               : ctrl_q;
  assign ctrl_set = {hi_wrap, lo_wrap, 6'b000000};

  // Count and reload registers; software writes override the count
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_lo_q <= `SCRT_RST_BYTE;
      cnt_hi_q <= `SCRT_RST_BYTE;
      rl_lo_q  <= `SCRT_RST_BYTE;
      rl_hi_q  <= `SCRT_RST_BYTE;
    end else if (ce_in) begin
      cnt_lo_q <= wr_cnt_lo ? wdata_in : cnt_lo_d;
      cnt_hi_q <= wr_cnt_hi ? wdata_in : cnt_hi_d;
      if (capture) begin
        rl_lo_q <= cnt_lo_q;
        rl_hi_q <= cnt_hi_q;
      end else begin
        rl_lo_q <= wr_rl_lo ? wdata_in : rl_lo_q;
        rl_hi_q <= wr_rl_hi ? wdata_in : rl_hi_q;
      end
    end
  end

  // Control and clock selection registers
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_q  <= `SCRT_RST_BYTE;
      ckctl_q <= `SCRT_RST_BYTE;
    end else if (ce_in) begin
      ctrl_q <= ctrl_wr_val | ctrl_set;
      if (wr_ckctl) begin
        ckctl_q <= wdata_in & `SCRT_CKCTL_WMASK;
      end
    end
  end

  // Interrupt events: high wrap, enabled low wrap, frame capture
  assign evt[`SCRT_EVT_HI]  = hi_wrap;
  assign evt[`SCRT_EVT_LO]  = lo_wrap & lo_ien;
  assign evt[`SCRT_EVT_CAP] = capture;

  scrt_irq u_irq (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rstn_in),
    .ce_in      (ce_in),
    .evt_in     (evt),
    .sts_wr_in  (wr_sts),
    .msk_wr_in  (wr_msk),
    .wdata_in   (wdata_in),
    .sts_out    (sts_w),
    .msk_out    (msk_w),
    .irq_out    (irq_out)
  );

  // Read selection; unmapped addresses read zero
  assign rd_mux =
    (addr_in == `SCRT_ADDR_CTRL)   ? ctrl_q   :
    (addr_in == `SCRT_ADDR_CKCTL)  ? ckctl_q  :
    (addr_in == `SCRT_ADDR_RL_LO)  ? rl_lo_q  :
    (addr_in == `SCRT_ADDR_RL_HI)  ? rl_hi_q  :
    (addr_in == `SCRT_ADDR_CNT_LO) ? cnt_lo_q :
    (addr_in == `SCRT_ADDR_CNT_HI) ? cnt_hi_q :
    (addr_in == `SCRT_ADDR_STS)    ? sts_w    :
    (addr_in == `SCRT_ADDR_MSK)    ? msk_w    : 8'h00;

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_q <= 8'h00;
    end else if (ce_in) begin
      rdata_q <= rd_in ? rd_mux : 8'h00;
    end
  end
  assign rdata_out = rdata_q;

  // Checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  wire no_cnt_wr = ~wr_cnt_lo & ~wr_cnt_hi;

  a_wrap_reload_load: assert property (
    ce_in && mode == SCRT_AUTO16 && hi_wrap && no_cnt_wr
    |=> {cnt_hi_q, cnt_lo_q} == $past({rl_hi_q, rl_lo_q})
        && ctrl_q[`SCRT_BIT_HI_FLAG])
    else $error("reload not loaded on 16-bit wrap");

  a_low_flag_set: assert property (
    ce_in && lo_wrap |=> ctrl_q[`SCRT_BIT_LO_FLAG])
    else $error("low flag not set on low byte wrap");

  a_flag_held_sticky: assert property (
    ctrl_q[`SCRT_BIT_HI_FLAG] && !wr_ctrl
    |=> ctrl_q[`SCRT_BIT_HI_FLAG])
    else $error("high flag cleared without software");

  a_split_byte_reload: assert property (
    ce_in && mode == SCRT_SPLIT8 && lo_wrap && !wr_cnt_lo
    |=> cnt_lo_q == $past(rl_lo_q))
    else $error("split low byte did not reload");

  a_stopped_count_hold: assert property (
    (!split && !run && no_cnt_wr) [*2]
    |-> $stable({cnt_hi_q, cnt_lo_q}))
    else $error("count moved while stopped");

  a_split_low_free: assert property (
    ce_in && split && !run && tick_lo && !wr_cnt_lo && cnt_lo_q != 8'hff
    |=> cnt_lo_q == $past(cnt_lo_q) + 8'h01)
    else $error("split low byte not free running");

  a_frame_capture_copy: assert property (
    ce_in && capture |=> {rl_hi_q, rl_lo_q} == $past(cnt16))
    else $error("frame capture did not copy count");

  a_unused_bit_zero: assert property (
    ce_in && rd_in && addr_in == `SCRT_ADDR_CTRL
    |=> !rdata_out[`SCRT_BIT_UNUSED])
    else $error("unused control bit read as one");

  a_irq_follows_flag: assert property (
    ce_in && hi_wrap && msk_w[`SCRT_EVT_HI] && !wr_msk
    ##1 ce_in |=> irq_out)
    else $error("enabled overflow gave no interrupt");

  a_ext_tick_sparse: assert property (
    ext8_tick |=> !ext8_tick [*2])
    else $error("external tick faster than synchroniser allows");

  c_auto_wrap: cover property (ce_in && mode == SCRT_AUTO16 && hi_wrap);
  c_split_both: cover property (ce_in && split && lo_wrap ##[1:600] hi_wrap);
  c_capture16: cover property (ce_in && mode == SCRT_CAP16 && capture);
  c_irq_rise: cover property ($rose(irq_out));

endmodule : scrt_timer
`default_nettype wire

// >>> dv/scrt_far_end.sv
// Far-side model: frame start source and free-running external oscillator
`timescale 1ns/1ps
`default_nettype none

module scrt_far_end (
  output logic      sof_pulse_out,
  output logic      ext_osc_out,
  output int        ext_edges_out,
  input  wire logic clk_sys_in
);
  // Oscillator runs free, its rate unrelated to the system clock
  initial begin
    sof_pulse_out = 1'b0;
    ext_osc_out   = 1'b0;
    ext_edges_out = 0;
    forever begin
      #37.3 ext_osc_out = ~ext_osc_out;
      if (ext_osc_out)
        ext_edges_out++;
    end
  end

  // One-cycle frame start pulse; caller enters just after a rising edge
  task automatic send_sof();
    sof_pulse_out <= 1'b1;
    @(posedge clk_sys_in);
    sof_pulse_out <= 1'b0;
  endtask : send_sof
endmodule : scrt_far_end
`default_nettype wire

// >>> dv/sof_capture_reload_timer_tb.sv
// Self-checking bench for the timer with a reference model
`timescale 1ns/1ps
`default_nettype none
`include "scrt_params.svh"

module sof_capture_reload_timer_tb;
  import scrt_pkg::*;

  logic       clk_sys_in;
  logic       rstn_in;
  logic       ce;
  logic       wr;
  logic       rd;
  logic [7:0] addr;
  scrt_byte_t wdata;
  scrt_byte_t rdata;
  logic       irq;
  logic       sof;
  logic       osc;
  int         edges;
  int         cyc = 0;
  int         t_wr;
  int         n_errors;
  int         compares;
  // Reference model state
  int         m_cnt;
  int         m_rl;
  int         m_steps;
  bit         m_hw;
  bit         m_lw;
  bit         m_split;
  bit         m_cap;

  scrt_timer dut_u (
    .clk_sys_in   (clk_sys_in),
    .rstn_in      (rstn_in),
    .ce_in        (ce),
    .ext_osc_in   (osc),
    .sof_pulse_in (sof),
    .addr_in      (addr),
    .wdata_in     (wdata),
    .wr_in        (wr),
    .rd_in        (rd),
    .rdata_out    (rdata),
    .irq_out      (irq)
  );

  scrt_far_end far_u (
    .sof_pulse_out (sof),
    .ext_osc_out   (osc),
    .ext_edges_out (edges),
    .clk_sys_in    (clk_sys_in)
  );

  // System clock and a cycle count that moves off the rising edge
  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  always @(negedge clk_sys_in) cyc <= cyc + 1;

  task automatic check(input scrt_byte_t seen, input scrt_byte_t exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input scrt_byte_t d);
    @(posedge clk_sys_in);
    t_wr = cyc;
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input scrt_byte_t exp);
    @(posedge clk_sys_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask : rd_chk

  // Advance the model by n count ticks
  task automatic model_run(input int n);
    int lo;
    int hi;
    repeat (n) begin
      lo = m_cnt & 255;
      hi = m_cnt >> 8;
      m_steps++;
      if (m_split) begin
        if (lo == 255) begin
          lo = m_cap ? 0 : (m_rl & 255);
          m_lw = 1'b1;
        end else
          lo++;
        if (hi == 255) begin
          hi = m_cap ? 0 : (m_rl >> 8);
          m_hw = 1'b1;
        end else
          hi++;
        m_cnt = hi * 256 + lo;
      end else begin
        if (lo == 255)
          m_lw = 1'b1;
        if (m_cnt == 65535) begin
          m_cnt = m_cap ? 0 : m_rl;
          m_hw = 1'b1;
        end else
          m_cnt++;
      end
    end
  endtask : model_run

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  // Watchdog against a hung run
  initial begin
    #200000;
    n_errors++;
    $display("CHECK FAILED at %0t: run timed out", $time);
    wrap_up();
  end

  initial begin
    int t0;
    int t_sof;
    int cap_v;
    int e0;
    int ex;
    scrt_byte_t ctrl;
    scrt_byte_t msk;
    scrt_byte_t sts;
    bit lo_en;
    {wr, rd, addr, wdata, n_errors, compares} = '0;
    ce      = 1'b1;
    rstn_in = 1'b0;
    void'($urandom(32'h1d01e7d7));
    repeat (10) @(posedge clk_sys_in);
    rstn_in <= 1'b1;

    // Reset values, unmapped place, unused control bit
    for (int a = 8'h8e; a <= 8'h97; a++)
      rd_chk(8'(a), 8'h00);
    wr_reg(8'h90, 8'h5a);
    rd_chk(8'h90, 8'h00);
    wr_reg(`SCRT_ADDR_CTRL, 8'h02);
    rd_chk(`SCRT_ADDR_CTRL, 8'h00);
    $display("test reset_values done");

    // Every mode twice, random start near wrap, reload and mask
    for (int it = 0; it < 8; it++) begin
      m_split = it[0];
      m_cap   = it[1];
      lo_en   = m_split ? 1'($urandom_range(1, 0)) : 1'b0;
      msk     = 8'($urandom_range(7, 0));
      m_rl    = $urandom_range(65535, 0) & 16'hbfbf;
      m_cnt   = (m_split ? 252 + $urandom_range(3, 0) : 255) * 256
                + 252 + $urandom_range(3, 0);
      {m_hw, m_lw, m_steps} = '0;
      wr_reg(`SCRT_ADDR_CNT_LO, 8'(m_cnt));
      wr_reg(`SCRT_ADDR_CNT_HI, 8'(m_cnt >> 8));
      wr_reg(`SCRT_ADDR_RL_LO, 8'(m_rl));
      wr_reg(`SCRT_ADDR_RL_HI, 8'(m_rl >> 8));
      wr_reg(`SCRT_ADDR_CKCTL, 8'h03);
      wr_reg(`SCRT_ADDR_MSK, msk);
      ctrl = {2'b00, lo_en, m_cap, m_split, 3'b100};
      wr_reg(`SCRT_ADDR_CTRL, ctrl);
      t0 = t_wr;
      repeat ($urandom_range(5, 1)) @(posedge clk_sys_in);
      @(posedge clk_sys_in);
      t_sof = cyc;
      far_u.send_sof();
      model_run(t_sof - t0 - 1);
      cap_v = m_cnt;
      model_run(4);
      repeat (8) @(posedge clk_sys_in);
      rd_chk(`SCRT_ADDR_CTRL, {m_hw, m_lw, ctrl[5:0]});
      sts = {5'b0, m_cap, m_lw & lo_en, m_hw};
      rd_chk(`SCRT_ADDR_STS, sts);
      check({7'b0, irq}, {7'b0, |(sts & msk)});
      wr_reg(`SCRT_ADDR_CTRL, 8'h00);
      model_run(t_wr - t0 - m_steps);
      rd_chk(`SCRT_ADDR_CNT_LO, 8'(m_cnt));
      rd_chk(`SCRT_ADDR_CNT_HI, 8'(m_cnt >> 8));
      ex = m_cap ? cap_v : m_rl;
      rd_chk(`SCRT_ADDR_RL_LO, 8'(ex));
      rd_chk(`SCRT_ADDR_RL_HI, 8'(ex >> 8));
      wr_reg(`SCRT_ADDR_STS, 8'h07);
      rd_chk(`SCRT_ADDR_STS, 8'h00);
      check({7'b0, irq}, 8'h00);
      $display("test mode %0d pass %0d done", it % 4, it / 4);
    end

    // Clock enable low freezes the free low byte and drops a write
    wr_reg(`SCRT_ADDR_CKCTL, 8'h03);
    wr_reg(`SCRT_ADDR_CNT_LO, 8'h00);
    wr_reg(`SCRT_ADDR_CNT_HI, 8'h00);
    wr_reg(`SCRT_ADDR_CTRL, 8'h08);
    ce <= 1'b0;
    repeat (20) @(posedge clk_sys_in);
    wr_reg(`SCRT_ADDR_CNT_HI, 8'h5a);
    t0 = t_wr;
    ce <= 1'b1;
    repeat (5) @(posedge clk_sys_in);
    wr_reg(`SCRT_ADDR_CTRL, 8'h00);
    rd_chk(`SCRT_ADDR_CNT_LO, 8'(t_wr - t0));
    rd_chk(`SCRT_ADDR_CNT_HI, 8'h00);
    $display("test clock enable done");

    // Split clocks: high byte on system clock, low on the shared source
    for (int xc = 0; xc < 2; xc++) begin
      wr_reg(`SCRT_ADDR_CNT_LO, 8'h00);
      wr_reg(`SCRT_ADDR_CNT_HI, 8'h00);
      wr_reg(`SCRT_ADDR_CKCTL, 8'h02);
      wr_reg(`SCRT_ADDR_CTRL, {7'b0000110, 1'(xc)});
      t0 = t_wr;
      e0 = edges;
      repeat (200) @(posedge clk_sys_in);
      wr_reg(`SCRT_ADDR_CTRL, 8'h00);
      rd_chk(`SCRT_ADDR_CNT_HI, 8'(t_wr - t0));
      ex = xc ? (edges - e0) / 8 : (t_wr - t0) / 12;
      @(posedge clk_sys_in);
      addr <= `SCRT_ADDR_CNT_LO;
      rd   <= 1'b1;
      @(posedge clk_sys_in);
      rd <= 1'b0;
      #1;
      // Divider phase and synchroniser delay allow one count either way
      if (int'(rdata) >= ex - 1 && int'(rdata) <= ex + 1 && !$isunknown(rdata))
        check(8'(ex), 8'(ex));
      else
        check(rdata, 8'(ex));
      $display("test clock source %0d done", xc);
    end
    wrap_up();
  end
endmodule : sof_capture_reload_timer_tb
`default_nettype wire
